// ==== hdl/gvb_bank.sv ====
// Vendor object attribute bank with an AXI4-Lite slave and an interrupt output.
// Assumes controller-side inputs are on core_clk_i; one write and one read at a time.
`timescale 1ns/1ps
`default_nettype none

module gvb_bank (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  // AXI4-Lite slave
  input  wire logic [gvb_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                      s_axi_awvalid_i,
  output logic                           s_axi_awready_o,
  input  wire logic [31:0]               s_axi_wdata_i,
  input  wire logic [3:0]                s_axi_wstrb_i,
  input  wire logic                      s_axi_wvalid_i,
  output logic                           s_axi_wready_o,
  output logic [1:0]                     s_axi_bresp_o,
  output logic                           s_axi_bvalid_o,
  input  wire logic                      s_axi_bready_i,
  input  wire logic [gvb_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                      s_axi_arvalid_i,
  output logic                           s_axi_arready_o,
  output logic [31:0]                    s_axi_rdata_o,
  output logic [1:0]                     s_axi_rresp_o,
  output logic                           s_axi_rvalid_o,
  input  wire logic                      s_axi_rready_i,
  // Controller logic side
  input  wire logic [49:0][7:0]          logic_to_plc_i,
  input  wire logic [31:0]               project_checksum_i,
  input  wire gvb_pkg::gvb_state0_t      state0_i,
  input  wire logic [59:1][7:0]          state_bytes_i,
  input  wire logic [7:0]                system_mode_i,
  input  wire logic                      err_evt_i,
  input  wire logic [31:0]               err_code_i,
  input  wire logic                      asm_wr_i,
  input  wire logic [5:0]                asm_wr_idx_i,
  input  wire logic [7:0]                asm_wr_data_i,
  output logic [49:0][7:0]               plc_to_logic_o,
  output logic [7:0]                     system_mode_o,
  output logic                           irq_o
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [49:0][7:0]                        plc_bytes_q;
  logic [gvb_pkg::ERR_DEPTH-1:0][31:0]     err_hist_q;
  logic [7:0]                              mode_q;
  logic [gvb_pkg::IRQ_W-1:0]               irq_sts_q;
  logic [gvb_pkg::IRQ_W-1:0]               irq_mask_q;
  logic                                    irq_q;

  // Write channel state
  logic                                    awready_q;
  logic                                    wready_q;
  logic                                    aw_full_q;
  logic                                    w_full_q;
  logic [gvb_pkg::ADDR_W-1:0]              awaddr_q;
  logic [31:0]                             wdata_q;
  logic [3:0]                              wstrb_q;
  logic                                    bvalid_q;
  logic [1:0]                              bresp_q;

  // Read channel state
  logic                                    arready_q;
  logic                                    rvalid_q;
  logic [31:0]                             rdata_q;
  logic [1:0]                              rresp_q;

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  gvb_pkg::gvb_rd_t rd;
  logic [2:0]       rd_inst;
  logic [5:0]       rd_attr;
  logic [7:0]       state0_byte;

  assign rd_inst = s_axi_araddr_i[gvb_pkg::INST_LSB +: 3];
  assign rd_attr = s_axi_araddr_i[gvb_pkg::ATTR_LSB +: 6];
  assign state0_byte = {state0_i, 1'b1};

  always_comb begin
    rd.err  = 1'b0;
    rd.data = 32'h0000_0000;
    case (rd_inst)
      gvb_pkg::INST_CLASS: begin
        case (rd_attr)
          gvb_pkg::CA_REVISION:  rd.data = {16'h0000, gvb_pkg::CLASS_REVISION};
          gvb_pkg::CA_MAX_INST:  rd.data = {16'h0000, gvb_pkg::CLASS_MAX_INST};
          gvb_pkg::CA_NUM_INST:  rd.data = {16'h0000, gvb_pkg::CLASS_NUM_INST};
          gvb_pkg::CA_SERVICES:  rd.data = {gvb_pkg::SVC_CODE_1, gvb_pkg::SVC_CODE_0};
          gvb_pkg::CA_SERVICES3: rd.data = {16'h0000, gvb_pkg::SVC_CODE_2};
          gvb_pkg::CA_MAX_CATTR: rd.data = {16'h0000, gvb_pkg::CLASS_MAX_CATTR};
          gvb_pkg::CA_MAX_IATTR: rd.data = {16'h0000, gvb_pkg::CLASS_MAX_IATTR};
          gvb_pkg::CA_IRQ_STS:   rd.data = {28'h0000000, irq_sts_q};
          gvb_pkg::CA_IRQ_MASK:  rd.data = {28'h0000000, irq_mask_q};
          default:               rd.err  = 1'b1;
        endcase
      end
      gvb_pkg::INST_TO_PLC: begin
        if (rd_attr >= 6'h01 && rd_attr <= 6'(gvb_pkg::IO_BYTES)) begin
          rd.data = {24'h000000, logic_to_plc_i[rd_attr - 6'h01]};
        end else begin
          rd.err = 1'b1;
        end
      end
      gvb_pkg::INST_CRC: begin
        if (rd_attr == 6'h01) begin
          rd.data = project_checksum_i;
        end else if (rd_attr > 6'h01 && rd_attr <= 6'(gvb_pkg::CRC_LAST_ATTR)) begin
          rd.data = 32'h0000_0000;
        end else begin
          rd.err = 1'b1;
        end
      end
      gvb_pkg::INST_STATE: begin
        if (rd_attr == 6'h01) begin
          rd.data = {24'h000000, state0_byte};
        end else if (rd_attr > 6'h01 && rd_attr <= 6'(gvb_pkg::STATE_BYTES)) begin
          rd.data = {24'h000000, state_bytes_i[rd_attr - 6'h01]};
        end else begin
          rd.err = 1'b1;
        end
      end
      gvb_pkg::INST_ADDL: begin
        if (rd_attr >= 6'h01 && rd_attr <= 6'(gvb_pkg::STATE_BYTES)) begin
          rd.data = 32'h0000_0000;
        end else begin
          rd.err = 1'b1;
        end
      end
      gvb_pkg::INST_MODE: begin
        if (rd_attr == 6'h01) begin
          rd.data = {24'h000000, mode_q};
        end else begin
          rd.err = 1'b1;
        end
      end
      gvb_pkg::INST_ERRHIST: begin
        if (rd_attr >= 6'h01 && rd_attr <= 6'(gvb_pkg::ERR_DEPTH)) begin
          rd.data = err_hist_q[3'(rd_attr - 6'h01)];
        end else begin
          rd.err = 1'b1;
        end
      end
      gvb_pkg::INST_FROM_PLC: begin
        if (rd_attr >= 6'h01 && rd_attr <= 6'(gvb_pkg::IO_BYTES)) begin
          rd.data = {24'h000000, plc_bytes_q[rd_attr - 6'h01]};
        end else begin
          rd.err = 1'b1;
        end
      end
      default: rd.err = 1'b1;
    endcase
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  logic       do_wr;
  logic [2:0] wr_inst;
  logic [5:0] wr_attr;
  logic       wr_err;
  logic       wr_plc;
  logic       wr_clr;
  logic       wr_sts;
  logic       wr_mask;

  assign do_wr   = aw_full_q && w_full_q && !bvalid_q;
  assign wr_inst = awaddr_q[gvb_pkg::INST_LSB +: 3];
  assign wr_attr = awaddr_q[gvb_pkg::ATTR_LSB +: 6];

  always_comb begin
    wr_err  = 1'b0;
    wr_plc  = 1'b0;
    wr_clr  = 1'b0;
    wr_sts  = 1'b0;
    wr_mask = 1'b0;
    if (wr_inst == gvb_pkg::INST_FROM_PLC && wr_attr >= 6'h01
        && wr_attr <= 6'(gvb_pkg::IO_BYTES)) begin
      wr_plc = wstrb_q[0];
    end else if (wr_inst == gvb_pkg::INST_ERRHIST && wr_attr == 6'h01
                 && wdata_q == 32'h0000_0000 && wstrb_q == 4'hF) begin
      wr_clr = 1'b1;
    end else if (wr_inst == gvb_pkg::INST_CLASS && wr_attr == gvb_pkg::CA_IRQ_STS) begin
      wr_sts = 1'b1;
    end else if (wr_inst == gvb_pkg::INST_CLASS && wr_attr == gvb_pkg::CA_IRQ_MASK) begin
      wr_mask = 1'b1;
    end else begin
      wr_err = 1'b1;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= gvb_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && awready_q) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_i;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_q) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata_i;
        wstrb_q  <= s_axi_wstrb_i;
        wready_q <= 1'b0;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_err ? gvb_pkg::RESP_SLVERR : gvb_pkg::RESP_OKAY;
      end
      if (bvalid_q && s_axi_bready_i) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= gvb_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd.err ? 32'h0000_0000 : rd.data;
        rresp_q   <= rd.err ? gvb_pkg::RESP_SLVERR : gvb_pkg::RESP_OKAY;
      end else if (rvalid_q && s_axi_rready_i) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // PLC-to-logic bytes, shared with the assembly port
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < gvb_pkg::IO_BYTES; gi++) begin : g_plc
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          plc_bytes_q[gi] <= 8'h00;
        end else if (do_wr && wr_plc && wr_attr == 6'(gi + 1)) begin
          plc_bytes_q[gi] <= wdata_q[7:0];
        end else if (asm_wr_i && asm_wr_idx_i == 6'(gi)) begin
          plc_bytes_q[gi] <= asm_wr_data_i;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Error history
  // ----------------------------------------
  logic err_push;
  assign err_push = err_evt_i && err_code_i != 32'h0000_0000;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_hist_q <= '0;
    end else if (err_push) begin
      // A clear in the same cycle drops old entries, the new one survives
      err_hist_q[0] <= err_code_i;
      for (int i = 1; i < gvb_pkg::ERR_DEPTH; i++) begin
        err_hist_q[i] <= (do_wr && wr_clr) ? 32'h0000_0000 : err_hist_q[i-1];
      end
    end else if (do_wr && wr_clr) begin
      err_hist_q <= '0;
    end
  end

  // ----------------------------------------
  // System mode
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= gvb_pkg::MODE_INIT;
    end else begin
      case (system_mode_i)
        gvb_pkg::MODE_INIT, gvb_pkg::MODE_CFG_REQ, gvb_pkg::MODE_CFG_LOAD,
        gvb_pkg::MODE_IDLE, gvb_pkg::MODE_RUN, gvb_pkg::MODE_CRIT_ERR,
        gvb_pkg::MODE_FORCE: mode_q <= system_mode_i;
        default:             mode_q <= mode_q;
      endcase
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  logic [gvb_pkg::IRQ_W-1:0] irq_evt;
  always_comb begin
    irq_evt = '0;
    irq_evt[gvb_pkg::IRQ_ERR_NEW] = err_push;
    irq_evt[gvb_pkg::IRQ_ERR_CLR] = do_wr && wr_clr;
    irq_evt[gvb_pkg::IRQ_PLC_WR]  = do_wr && wr_plc;
    irq_evt[gvb_pkg::IRQ_BUS_ERR] = (do_wr && wr_err) || (s_axi_arvalid_i && arready_q && rd.err);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_sts_q  <= '0;
      irq_mask_q <= gvb_pkg::IRQ_MASK_RST;
      irq_q      <= 1'b0;
    end else begin
      if (do_wr && wr_sts) begin
        irq_sts_q <= (irq_sts_q & ~wdata_q[gvb_pkg::IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_sts_q <= irq_sts_q | irq_evt;
      end
      if (do_wr && wr_mask) begin
        irq_mask_q <= wdata_q[gvb_pkg::IRQ_W-1:0];
      end
      irq_q <= |(irq_sts_q & irq_mask_q);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;
  assign plc_to_logic_o  = plc_bytes_q;
  assign system_mode_o   = mode_q;
  assign irq_o           = irq_q;

endmodule // gvb_bank

`default_nettype wire

// ==== hdl/gvb_pkg.sv ====
// Package for the vendor object attribute bank: address map, codes, reset values.
// Assumes a single 20 MHz clock and a 32-bit AXI4-Lite register bus.
package gvb_pkg;

  // ----------------------------------------
  // Address layout: byte address = {instance, attribute, 2'b00}
  // ----------------------------------------
  localparam int unsigned ADDR_W      = 11;
  localparam int unsigned ATTR_LSB    = 2;
  localparam int unsigned INST_LSB    = 8;

  localparam logic [2:0] INST_CLASS   = 3'h0;
  localparam logic [2:0] INST_TO_PLC  = 3'h1;
  localparam logic [2:0] INST_CRC     = 3'h2;
  localparam logic [2:0] INST_STATE   = 3'h3;
  localparam logic [2:0] INST_ADDL    = 3'h4;
  localparam logic [2:0] INST_MODE    = 3'h5;
  localparam logic [2:0] INST_ERRHIST = 3'h6;
  localparam logic [2:0] INST_FROM_PLC = 3'h7;

  // ----------------------------------------
  // Class attributes
  // ----------------------------------------
  localparam logic [5:0] CA_REVISION  = 6'h01;
  localparam logic [5:0] CA_MAX_INST  = 6'h02;
  localparam logic [5:0] CA_NUM_INST  = 6'h03;
  localparam logic [5:0] CA_SERVICES  = 6'h05;
  localparam logic [5:0] CA_MAX_CATTR = 6'h06;
  localparam logic [5:0] CA_MAX_IATTR = 6'h07;
  localparam logic [5:0] CA_SERVICES3 = 6'h15;
  localparam logic [5:0] CA_IRQ_STS   = 6'h20;
  localparam logic [5:0] CA_IRQ_MASK  = 6'h21;

  localparam logic [15:0] CLASS_REVISION = 16'h0001;
  localparam logic [15:0] CLASS_MAX_INST = 16'h0004;
  localparam logic [15:0] CLASS_NUM_INST = 16'h0004;
  localparam logic [15:0] SVC_CODE_0     = 16'h0002;
  localparam logic [15:0] SVC_CODE_1     = 16'h004C;
  localparam logic [15:0] SVC_CODE_2     = 16'h004D;
  localparam logic [15:0] CLASS_MAX_CATTR = 16'h0007;
  localparam logic [15:0] CLASS_MAX_IATTR = 16'h003C;

  // ----------------------------------------
  // Sizes and attribute ranges
  // ----------------------------------------
  localparam int unsigned IO_BYTES    = 50;
  localparam int unsigned STATE_BYTES = 60;
  localparam int unsigned ERR_DEPTH   = 5;
  localparam int unsigned CRC_LAST_ATTR = 8;

  // ----------------------------------------
  // System mode codes
  // ----------------------------------------
  localparam logic [7:0] MODE_INIT     = 8'h01;
  localparam logic [7:0] MODE_CFG_REQ  = 8'h02;
  localparam logic [7:0] MODE_CFG_LOAD = 8'h03;
  localparam logic [7:0] MODE_IDLE     = 8'h04;
  localparam logic [7:0] MODE_RUN      = 8'h05;
  localparam logic [7:0] MODE_CRIT_ERR = 8'h07;
  localparam logic [7:0] MODE_FORCE    = 8'h15;

  // ----------------------------------------
  // Interrupt status bits and bus answers
  // ----------------------------------------
  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned IRQ_ERR_NEW  = 0;
  localparam int unsigned IRQ_ERR_CLR  = 1;
  localparam int unsigned IRQ_PLC_WR   = 2;
  localparam int unsigned IRQ_BUS_ERR  = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Controller state byte 0, 1 = OK, 0 = fault
  typedef struct packed {
    logic second_supply_two;
    logic fast_shutoff;
    logic second_supply_one;
    logic config_ok;
    logic main_supply_pair;
    logic ext_module;
    logic int_module;
  } gvb_state0_t;

  // Answer of the attribute decoder
  typedef struct packed {
    logic        err;
    logic [31:0] data;
  } gvb_rd_t;

endpackage

// ==== tb/gateway_vendor_object_bank_test.sv ====
// Self-checking bench for the attribute bank with a PLC master model.
// Assumes the package, bank, model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module gateway_vendor_object_bank_test;
  localparam logic [1:0] OK = gvb_pkg::RESP_OKAY;
  localparam logic [1:0] ER = gvb_pkg::RESP_SLVERR;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [10:0] awaddr, araddr;
  logic [31:0] wdata, rdata, crc = '0, ec = '0, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, ev = 1'b0, aw = 1'b0;
  logic [49:0][7:0] l2p = '0, p2l;
  logic [59:1][7:0] stb = '0;
  gvb_pkg::gvb_state0_t st0 = '0;
  logic [7:0] mode = 8'h01, mode_o, ad = '0;
  logic [5:0] ai = '0;
  int failures = 0, samples_checked = 0, cyc = 0, seed = 32'hec4eb95f, em = 1;
  int plc_q[50];
  int hist[$];
  int codes[9] = '{1, 2, 3, 4, 5, 7, 21, 6, 0};
  always #25 clk = ~clk;
  gvb_bank i_dut (.core_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .logic_to_plc_i(l2p), .project_checksum_i(crc), .state0_i(st0),
    .state_bytes_i(stb), .system_mode_i(mode), .err_evt_i(ev), .err_code_i(ec),
    .asm_wr_i(aw), .asm_wr_idx_i(ai), .asm_wr_data_i(ad), .plc_to_logic_o(p2l),
    .system_mode_o(mode_o), .irq_o(irq));
  gvb_plc_model i_plc (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
    .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
  // ------
  // Compare and report
  // ------
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  function automatic logic [10:0] ia(input int i, input int t);
    return {i[2:0], t[5:0], 2'b00};
  endfunction
  task automatic rdc(input logic [10:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_plc.rd(a, d, r);
    chk(d, e, "read data");
    chk(32'(r), 32'(er), "read response");
  endtask
  task automatic wrc(input logic [10:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
    logic [1:0] r;
    i_plc.wr(a, d, s, r);
    chk(32'(r), 32'(er), "write response");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict;
    end
  end
  // ------
  // Main sequence
  // ------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(ia(0, 1), 32'h1, OK);
    rdc(ia(0, 2), 32'h4, OK);
    rdc(ia(0, 3), 32'h4, OK);
    rdc(ia(0, 5), 32'h004C0002, OK);
    rdc(ia(0, 21), 32'h4D, OK);
    rdc(ia(0, 6), 32'h7, OK);
    rdc(ia(0, 7), 32'h3C, OK);
    wrc(ia(0, 1), 32'h5, 4'hF, ER);
    wrc(ia(4, 1), 32'h5, 4'hF, ER);
    rdc(ia(0, 63), 32'h0, ER);
    $display("class test done");
    for (int n = 0; n < 50; n++) l2p[n] <= 8'($random(seed));
    for (int n = 1; n < 60; n++) stb[n] <= 8'($random(seed));
    crc <= $random(seed);
    st0 <= 7'($random(seed));
    @(posedge clk);
    rdc(ia(1, 1), {24'h0, l2p[0]}, OK);
    rdc(ia(1, 50), {24'h0, l2p[49]}, OK);
    rdc(ia(1, 51), 32'h0, ER);
    rdc(ia(2, 1), crc, OK);
    for (int t = 2; t < 9; t++) rdc(ia(2, t), 32'h0, OK);
    rdc(ia(3, 1), {24'h0, st0, 1'b1}, OK);
    for (int n = 1; n < 60; n++) rdc(ia(3, n + 1), {24'h0, stb[n]}, OK);
    for (int t = 1; t < 61; t++) rdc(ia(4, t), 32'h0, OK);
    $display("data test done");
    foreach (codes[k]) begin
      mode <= codes[k][7:0];
      if (codes[k] inside {1, 2, 3, 4, 5, 7, 21}) em = codes[k];
      rdc(ia(5, 1), em, OK);
      chk({24'h0, mode_o}, em, "mode output");
    end
    $display("mode test done");
    for (int k = 0; k < 7; k++) begin
      v = (k == 3) ? 32'h0 : ($random(seed) | 32'h1);
      if (v != 0) hist.push_front(v);
      if (hist.size() > 5) void'(hist.pop_back());
      ev <= 1'b1;
      ec <= v;
      @(posedge clk);
      ev <= 1'b0;
      @(posedge clk);
    end
    @(posedge clk);
    chk(32'(irq), 32'h0, "masked irq");
    wrc(ia(0, 33), 32'h1, 4'hF, OK);
    @(posedge clk);
    chk(32'(irq), 32'h1, "unmasked irq");
    for (int t = 1; t < 6; t++) rdc(ia(6, t), hist[t - 1], OK);
    wrc(ia(6, 1), 32'h3, 4'hF, ER);
    rdc(ia(6, 1), hist[0], OK);
    wrc(ia(6, 1), 32'h0, 4'hF, OK);
    for (int t = 1; t < 6; t++) rdc(ia(6, t), 32'h0, OK);
    wrc(ia(0, 32), 32'hF, 4'hF, OK);
    @(posedge clk);
    chk(32'(irq), 32'h0, "cleared irq");
    $display("history test done");
    i_plc.slow = 3;
    for (int n = 0; n < 50; n++) begin
      v = $random(seed);
      wrc(ia(7, n + 1), v, 4'hF, OK);
      plc_q[n] = v[7:0];
      rdc(ia(7, n + 1), plc_q[n], OK);
      chk({24'h0, p2l[n]}, plc_q[n], "logic byte");
    end
    wrc(ia(7, 1), 32'hAA, 4'hE, OK);
    rdc(ia(7, 1), plc_q[0], OK);
    ai <= 6'd7;
    ad <= 8'h5A;
    aw <= 1'b1;
    @(posedge clk);
    ai <= 6'd50;
    plc_q[7] = 8'h5A;
    @(posedge clk);
    aw <= 1'b0;
    rdc(ia(7, 8), plc_q[7], OK);
    for (int n = 0; n < 50; n++) chk({24'h0, p2l[n]}, plc_q[n], "logic byte");
    $display("plc data test done");
    print_verdict;
  end
endmodule // gateway_vendor_object_bank_test
bind gvb_bank gvb_bank_chk i_chk (.*);
`default_nettype wire

// ==== tb/gvb_bank_chk.sv ====
// Checker for the attribute bank; sees only the bank's ports.
// Assumes one clock domain with an active-high reset.
`timescale 1ns/1ps
`default_nettype none
module gvb_bank_chk (
  input wire logic             core_clk_i,
  input wire logic             rst_i,
  input wire logic [10:0]      s_axi_awaddr_i,
  input wire logic             s_axi_awvalid_i,
  input wire logic             s_axi_awready_o,
  input wire logic             s_axi_wvalid_i,
  input wire logic             s_axi_wready_o,
  input wire logic [1:0]       s_axi_bresp_o,
  input wire logic             s_axi_bvalid_o,
  input wire logic             s_axi_bready_i,
  input wire logic [10:0]      s_axi_araddr_i,
  input wire logic             s_axi_arvalid_i,
  input wire logic             s_axi_arready_o,
  input wire logic [31:0]      s_axi_rdata_o,
  input wire logic [1:0]       s_axi_rresp_o,
  input wire logic             s_axi_rvalid_o,
  input wire logic             s_axi_rready_i,
  input wire logic [31:0]      project_checksum_i,
  input wire logic [6:0]       state0_i,
  input wire logic [7:0]       system_mode_i,
  input wire logic             asm_wr_i,
  input wire logic [5:0]       asm_wr_idx_i,
  input wire logic [7:0]       asm_wr_data_i,
  input wire logic [49:0][7:0] plc_to_logic_o,
  input wire logic [7:0]       system_mode_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ------
  // Handshake sequences
  // ------
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  logic mode_ok;
  assign mode_ok = system_mode_i inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h15};
  // ------
  // Assertions
  // ------
  a_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write answer lost");
  a_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer lost");
  a_rev_read: assert property (s_rd_take ##0 s_axi_araddr_i == 11'h004 |=>
    s_axi_rdata_o == 32'h1 && s_axi_rresp_o == 2'h0) else $error("revision wrong");
  a_iattr_read: assert property (s_rd_take ##0 s_axi_araddr_i == 11'h01C |=>
    s_axi_rdata_o == 32'h3C) else $error("max attr wrong");
  a_crc_read: assert property (s_rd_take ##0 s_axi_araddr_i == 11'h204 |=>
    s_axi_rdata_o == $past(project_checksum_i)) else $error("checksum wrong");
  a_state_zero: assert property (s_rd_take ##0 s_axi_araddr_i == 11'h304 |=>
    s_axi_rdata_o == {24'h0, $past(state0_i), 1'b1}) else $error("state byte 0 wrong");
  a_addl_zero: assert property (s_rd_take ##0 s_axi_araddr_i[10:8] == 3'h4 |=>
    s_axi_rdata_o == 32'h0) else $error("extra byte set");
  a_mode_legal: assert property (system_mode_o inside
    {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h15}) else $error("illegal mode shown");
  a_mode_take: assert property (mode_ok |=> system_mode_o == $past(system_mode_i))
    else $error("mode not taken");
  a_mode_hold: assert property (!mode_ok |=> $stable(system_mode_o))
    else $error("mode changed");
  a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid_o)
    else $error("write answer late");
  a_ro_refuse: assert property (s_wr_take ##0 s_axi_awaddr_i[10:8] == 3'h4 |-> ##2
    s_axi_bvalid_o && s_axi_bresp_o == 2'h2) else $error("read-only written");
  a_asm_lands: assert property (asm_wr_i && asm_wr_idx_i < 6'd50 && s_axi_awready_o &&
    s_axi_wready_o |=>
    plc_to_logic_o[$past(asm_wr_idx_i)] == $past(asm_wr_data_i)) else $error("asm write lost");
endmodule // gvb_bank_chk
`default_nettype wire

// ==== tb/gvb_plc_model.sv ====
// Remote PLC model: AXI4-Lite master that reads and writes bank attributes.
// Assumes one shared core clock; the bench's timeout ends any hung wait.
`timescale 1ns/1ps
`default_nettype none
module gvb_plc_model (
  input  wire logic        clk_i,
  output logic [10:0]      awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [10:0]      araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  // Answer delay in cycles
  int slow = 0;
  initial begin
    {awaddr_o, araddr_o, wdata_o, wstrb_o} = '0;
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
  end
  // ------
  // Write: AW and W together, then B
  // ------
  task automatic wr(input logic [10:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n = 0;
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= s;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (bvalid_i && bready_o) begin
        r = bresp_i;
        bready_o <= 1'b0;
        break;
      end
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
      n++;
      if (n >= slow) bready_o <= 1'b1;
    end
  endtask
  // ------
  // Read: AR, then R
  // ------
  task automatic rd(input logic [10:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (rvalid_i && rready_o) begin
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
        break;
      end
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
      n++;
      if (n >= slow) rready_o <= 1'b1;
    end
  endtask
endmodule // gvb_plc_model
`default_nettype wire
